// ==== bench/cap_fields_monitor.sv ====
// Port checker for the capability field bank.
// Assumes a root port build with a legacy pin selected.
`timescale 1ns/1ps
module cap_fields_monitor
   import cap_fields_pkg::*;
#(
   parameter logic [2:0] MMC = 3'h3
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire cap_fields_pkg::cfg_req_s cfg_req,
   input wire cap_fields_pkg::cfg_rsp_s cfg_rsp,
   input wire logic link_active_in,
   input wire logic app_int_req,
   input wire logic core_int_ack,
   input wire logic legacy_int_out,
   input wire logic app_int_ack,
   input wire logic msi_enable,
   input wire logic [2:0] msi_multi_enabled,
   input wire logic msix_enable,
   input wire logic link_disable,
   input wire logic link_layer_active_state,
   input wire logic surprise_down_event
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // ==========================================================================
   // Sequences
   sequence s_link_up;
      $rose(link_active_in) ##1 link_active_in [*3];
   endsequence
   sequence s_link_down;
      $fell(link_active_in) ##1 !link_active_in [*3];
   endsequence

   // ==========================================================================
   // Properties
   property p_rsp; (cfg_req.rd || cfg_req.wr) |=> cfg_rsp.valid; endproperty
   property p_no_rsp; cfg_rsp.valid |-> $past(cfg_req.rd || cfg_req.wr); endproperty
   property p_wr_zero; cfg_req.wr |=> cfg_rsp.rdata == 32'h00000000; endproperty
   property p_legacy;
      legacy_int_out == $past(app_int_req && !msi_enable && !msix_enable);
   endproperty
   property p_ack; app_int_ack == $past(core_int_ack); endproperty
   property p_dla_up; s_link_up |-> link_layer_active_state; endproperty
   property p_dla_down; s_link_down |-> !link_layer_active_state; endproperty
   property p_sd; $fell(link_active_in) && !link_disable |-> ##[2:4] surprise_down_event;
   endproperty
   property p_sd_pulse; surprise_down_event |=> !surprise_down_event; endproperty
   property p_mme; msi_multi_enabled <= MMC; endproperty

   a_rsp: assert property (p_rsp) else $error("No answer to a request");
   a_no_rsp: assert property (p_no_rsp) else $error("Answer without request");
   a_wr_zero: assert property (p_wr_zero) else $error("Write answer not zero");
   a_legacy: assert property (p_legacy) else $error("Legacy output wrong");
   a_ack: assert property (p_ack) else $error("Legacy ack wrong");
   a_dla_up: assert property (p_dla_up) else $error("Active state not seen");
   a_dla_down: assert property (p_dla_down) else $error("Active state stuck");
   a_sd: assert property (p_sd) else $error("Surprise down missed");
   a_sd_pulse: assert property (p_sd_pulse) else $error("Surprise down too long");
   a_mme: assert property (p_mme) else $error("Enabled count above capable");
endmodule // cap_fields_monitor

bind cap_fields cap_fields_monitor mon (.mclk(mclk), .rstn(rstn),
   .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .link_active_in(link_active_in),
   .app_int_req(app_int_req), .core_int_ack(core_int_ack), .legacy_int_out(legacy_int_out),
   .app_int_ack(app_int_ack), .msi_enable(msi_enable), .msi_multi_enabled(msi_multi_enabled),
   .msix_enable(msix_enable), .link_disable(link_disable),
   .link_layer_active_state(link_layer_active_state),
   .surprise_down_event(surprise_down_event));

// ==== bench/cfg_host.sv ====
// Host software model issuing configuration requests to the bank.
// Assumes requests are launched at falling edges and answered one cycle later.
`timescale 1ns/1ps
module cfg_host
   import cap_fields_pkg::*;
(
   input wire logic mclk,
   output cap_fields_pkg::cfg_req_s cfg_req,
   input wire cap_fields_pkg::cfg_rsp_s cfg_rsp
);
   initial cfg_req = '0;

   // Software drops the selector bits to get a qword-aligned offset.
   function automatic logic [31:0] qword_offset(input logic [31:0] w);
      return {w[31:3], 3'h0};
   endfunction

   task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                         input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
      ok = 1'b0;
      rdata = 32'h0;
      @(negedge mclk);
      cfg_req = '{rd: !wr, wr: wr, addr: addr, be: be, wdata: wdata};
      @(negedge mclk);
      // Released lines show the inverse so stale values are never mistaken for live ones.
      cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, be: ~be, wdata: ~wdata};
      for (int i = 0; i < 4 && !ok; i++)
      begin
         if (cfg_rsp.valid === 1'b1)
         begin
            ok = 1'b1;
            rdata = cfg_rsp.rdata;
         end
         else
            @(negedge mclk);
      end
   endtask
endmodule // cfg_host

// ==== bench/pcie_capability_fields_bench.sv ====
// Self-checking bench for the capability field bank, built as a hot-plug root port.
// Assumes the host model drives all configuration requests.
`timescale 1ns/1ps
module pcie_capability_fields_bench;
   import cap_fields_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   cfg_req_s cfg_req;
   cfg_rsp_s cfg_rsp;
   logic link_active_in, app_int_req, core_int_ack, legacy_int_out, app_int_ack;
   logic msi_enable, msix_enable, msix_function_mask, flr_request, link_disable;
   logic link_layer_active_state, surprise_down_event, ok, seen;
   logic [2:0] msi_multi_enabled;
   logic [31:0] rd;
   logic [11:0] ro_a [5];
   logic [31:0] ro_e [5];
   int miscompares = 0;
   int checked = 0;

   always #5 mclk = ~mclk;

   cfg_host host (.mclk(mclk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

   // FLR is asked for but must stay off because this is a root port.
   localparam logic FLR_ON = 1'b1;
   localparam port_type_e PORT_TYPE = PORT_ROOT;
   localparam logic HOT_PLUG_ON = 1'b1;
   localparam logic SURPRISE_DOWN_ON = 1'b1;
   localparam int MSI_MESSAGES = 8;
   localparam logic MSIX_ON = 1'b1;
   localparam logic [10:0] MSIX_TABLE_SIZE = 11'h7ff;
   localparam logic [31:0] MSIX_TABLE_OFFSET = 32'h0001234f;
   localparam logic [2:0] MSIX_TABLE_BAR = 3'h5;
   // An out-of-range selector checks that the bank folds it to zero.
   localparam logic [31:0] PENDING_OFFSET = 32'h00000f07;
   localparam logic [2:0] PENDING_BAR = 3'h7;
   localparam legacy_pin_e LEGACY_PIN = INT_C;

   cap_fields #(.FLR_ON(FLR_ON), .PORT_TYPE(PORT_TYPE), .HOT_PLUG_ON(HOT_PLUG_ON),
      .SURPRISE_DOWN_ON(SURPRISE_DOWN_ON), .MSI_MESSAGES(MSI_MESSAGES), .MSIX_ON(MSIX_ON),
      .MSIX_TABLE_SIZE(MSIX_TABLE_SIZE), .MSIX_TABLE_OFFSET(MSIX_TABLE_OFFSET),
      .MSIX_TABLE_BAR(MSIX_TABLE_BAR), .PENDING_OFFSET(PENDING_OFFSET),
      .PENDING_BAR(PENDING_BAR), .LEGACY_PIN(LEGACY_PIN)) dut (
      .mclk(mclk), .rstn(rstn), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
      .link_active_in(link_active_in), .app_int_req(app_int_req),
      .core_int_ack(core_int_ack), .legacy_int_out(legacy_int_out),
      .app_int_ack(app_int_ack), .msi_enable(msi_enable),
      .msi_multi_enabled(msi_multi_enabled), .msix_enable(msix_enable),
      .msix_function_mask(msix_function_mask), .flr_request(flr_request),
      .link_disable(link_disable), .link_layer_active_state(link_layer_active_state),
      .surprise_down_event(surprise_down_event));

   // ==========================================================================
   // Tasks
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic access(input logic w, input logic [11:0] a, input logic [3:0] be,
                         input logic [31:0] d);
      host.access(w, a, be, d, rd, ok);
      if (ok !== 1'b1)
      begin
         miscompares++;
         end_of_test();
      end
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      access(1'b0, a, 4'hf, 32'h0);
      cmp(rd & m, e);
   endtask

   task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      access(1'b1, a, be, d);
      cmp(rd, 32'h0);
   endtask

   task automatic ticks(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // ==========================================================================
   // Main sequence
   initial
   begin
      link_active_in = 1'b0;
      app_int_req = 1'b0;
      core_int_ack = 1'b0;
      ro_a = '{12'h090, 12'h06c, 12'h070, 12'h03c, 12'h200};
      ro_e = '{32'h00180000, host.qword_offset(MSIX_TABLE_OFFSET) | {29'h0, MSIX_TABLE_BAR},
               host.qword_offset(PENDING_OFFSET), {21'h0, LEGACY_PIN, 8'h00}, 32'h0};
      ticks(2);
      rstn = 1'b1;
      ticks(4);
      for (int i = 0; i < 5; i++)
      begin
         rd_chk(ro_a[i], 32'hffffffff, ro_e[i]);
         wr(ro_a[i], 4'he, 32'hffffffff);
         rd_chk(ro_a[i], 32'hffffffff, ro_e[i]);
      end
      rd_chk(12'h084, 32'h10000000, 32'h0);
      wr(12'h088, 4'h2, 32'h00008000);
      cmp({31'h0, flr_request}, 32'h0);
      rd_chk(12'h050, 32'hffffffff, 32'h00066805);
      $display("Test read_only_words done");
      wr(12'h050, 4'h4, 32'h00710000);
      cmp({29'h0, msi_multi_enabled}, 32'h3);
      rd_chk(12'h050, 32'hffffffff, 32'h00376805);
      app_int_req = 1'b1;
      ticks(2);
      cmp({31'h0, legacy_int_out}, 32'h0);
      wr(12'h050, 4'h4, 32'h0);
      ticks(2);
      cmp({31'h0, legacy_int_out}, 32'h1);
      core_int_ack = 1'b1;
      ticks(2);
      cmp({31'h0, app_int_ack}, 32'h1);
      core_int_ack = 1'b0;
      app_int_req = 1'b0;
      $display("Test msi_and_legacy done");
      wr(12'h068, 4'h8, 32'hffffffff);
      cmp({30'h0, msix_enable, msix_function_mask}, 32'h3);
      rd_chk(12'h068, 32'hffffffff, 32'hc7ff8011);
      wr(12'h068, 4'h8, 32'h0);
      cmp({30'h0, msix_enable, msix_function_mask}, 32'h0);
      $display("Test msix done");
      link_active_in = 1'b1;
      ticks(5);
      cmp({31'h0, link_layer_active_state}, 32'h1);
      rd_chk(12'h094, 32'h20000000, 32'h20000000);
      link_active_in = 1'b0;
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++)
      begin
         ticks(1);
         seen = surprise_down_event;
      end
      cmp({31'h0, seen}, 32'h1);
      rd_chk(12'h104, 32'h00000020, 32'h00000020);
      wr(12'h104, 4'h1, 32'h00000020);
      rd_chk(12'h104, 32'h00000020, 32'h0);
      // A drop that software asked for must not be reported as a surprise.
      wr(12'h094, 4'h1, 32'h00000010);
      cmp({31'h0, link_disable}, 32'h1);
      link_active_in = 1'b1;
      ticks(5);
      link_active_in = 1'b0;
      ticks(6);
      rd_chk(12'h104, 32'h00000020, 32'h0);
      wr(12'h094, 4'h1, 32'h0);
      rd_chk(12'h094, 32'h20000010, 32'h0);
      $display("Test link_events done");
      end_of_test();
   end
endmodule // pcie_capability_fields_bench

// ==== hdl/cap_fields.sv ====
// Configuration-space capability fields of one PCI Express function.
// Assumes configuration requests arrive one at a time on mclk, and that the
// link-active level comes from the link side and must be synchronised.
//
// What this block does
// - FLR capable bit set when enabled, endpoints only.
// - Downstream port advertises link-layer-active reporting when chosen.
// - Hot-plug downstream port always advertises active reporting.
// - Root port detects and reports surprise link down.
// - MSI message count encoded into multiple-message-capable field.
// - MSIX_CAPABILITY_CONTROL structure present only when enabled.
// - MSIX_CAPABILITY_CONTROL table size is 11-bit entries minus one.
// - Table offset word carries qword offset and selector.
// - Table bar_selector is 3 bits, legal 0 to 5.
// - Pending array offset word is qword-aligned.
// - pending_bit_array bar_selector is 3 bits, 0 to 5.
// - Legacy pin A-D or none, passed to application.
`timescale 1ns/1ps
`include "cap_fields_cfg.svh"
module cap_fields #(
   parameter logic FLR_ON = 1'b0,
   parameter cap_fields_pkg::port_type_e PORT_TYPE = cap_fields_pkg::PORT_ENDPOINT,
   parameter logic DLA_REPORT_ON = 1'b0,
   parameter logic HOT_PLUG_ON = 1'b0,
   parameter logic SURPRISE_DOWN_ON = 1'b0,
   parameter int MSI_MESSAGES = 1,
   parameter logic MSIX_ON = 1'b0,
   parameter logic [10:0] MSIX_TABLE_SIZE = 11'h000,
   parameter logic [31:0] MSIX_TABLE_OFFSET = 32'h00000000,
   parameter logic [2:0] MSIX_TABLE_BAR = 3'h0,
   parameter logic [31:0] PENDING_OFFSET = 32'h00000000,
   parameter logic [2:0] PENDING_BAR = 3'h0,
   parameter cap_fields_pkg::legacy_pin_e LEGACY_PIN = cap_fields_pkg::INT_A
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire cap_fields_pkg::cfg_req_s cfg_req,
   output cap_fields_pkg::cfg_rsp_s cfg_rsp,
   input wire logic link_active_in,
   input wire logic app_int_req,
   input wire logic core_int_ack,
   output logic legacy_int_out,
   output logic app_int_ack,
   output logic msi_enable,
   output logic [2:0] msi_multi_enabled,
   output logic msix_enable,
   output logic msix_function_mask,
   output logic flr_request,
   output logic link_disable,
   output logic link_layer_active_state,
   output logic surprise_down_event
);
   import cap_fields_pkg::*;

   // ==========================================================================
   // Reset release
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ==========================================================================
   // Fixed build-time values
   function automatic logic [2:0] mmc_code(input int n);
      logic [2:0] c;
      c = 3'h0;
      case (n)
         2: c = 3'h1;
         4: c = 3'h2;
         8: c = 3'h3;
         16: c = 3'h4;
         default: c = 3'h0;
      endcase
      return c;
   endfunction

   // An illegal selector above 5 folds to 0 so software never sees an unmapped BAR.
   function automatic logic [2:0] bar_fold(input logic [2:0] b);
      return (b > `BAR_LAST) ? 3'h0 : b;
   endfunction

   localparam logic IS_ROOT = (PORT_TYPE == PORT_ROOT);
   localparam logic FLR_CAP = FLR_ON && !IS_ROOT;
   localparam logic HP_CAP = HOT_PLUG_ON && IS_ROOT;
   localparam logic DLA_CAP = IS_ROOT && (DLA_REPORT_ON || HOT_PLUG_ON);
   localparam logic SD_CAP = SURPRISE_DOWN_ON && IS_ROOT;
   localparam logic [2:0] MMC = mmc_code(MSI_MESSAGES);
   localparam logic [2:0] TABLE_SEL = bar_fold(MSIX_TABLE_BAR);
   localparam logic [2:0] PENDING_SEL = bar_fold(PENDING_BAR);
   localparam logic [7:0] MSI_NEXT = 8'(MSIX_ON ? `OFF_MSIX_CTRL : `OFF_PCIE_CAP);

   // ==========================================================================
   // Write decode
   logic wr_int_line;
   logic wr_msi;
   logic wr_msix;
   logic wr_dev_ctrl;
   logic wr_link_ctrl;
   logic wr_err;

   // Writes to any other offset, including the read-only words, store nothing.
   assign wr_int_line = cfg_req.wr && (cfg_req.addr == `OFF_INT_LINE);
   assign wr_msi = cfg_req.wr && (cfg_req.addr == `OFF_MSI_CTRL);
   assign wr_msix = cfg_req.wr && (cfg_req.addr == `OFF_MSIX_CTRL) && MSIX_ON;
   assign wr_dev_ctrl = cfg_req.wr && (cfg_req.addr == `OFF_DEV_CTRL);
   assign wr_link_ctrl = cfg_req.wr && (cfg_req.addr == `OFF_LINK_CTRL);
   assign wr_err = cfg_req.wr && (cfg_req.addr == `OFF_ERR_STATUS);

   // ==========================================================================
   // Writable control fields
   logic [7:0] int_line_q;

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         int_line_q <= `RST_INT_LINE;
      else if (wr_int_line && cfg_req.be[0])
         int_line_q <= cfg_req.wdata[7:0];
   end

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         msi_enable <= `RST_BIT;
         msi_multi_enabled <= `RST_MME;
      end
      else if (wr_msi && cfg_req.be[2])
      begin
         msi_enable <= cfg_req.wdata[`BIT_MSI_EN];
         // Software may not enable more vectors than advertised.
         if (cfg_req.wdata[`MSI_MME_LSB +: 3] > MMC)
            msi_multi_enabled <= MMC;
         else
            msi_multi_enabled <= cfg_req.wdata[`MSI_MME_LSB +: 3];
      end
   end

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         msix_enable <= `RST_BIT;
         msix_function_mask <= `RST_BIT;
      end
      else if (wr_msix && cfg_req.be[3])
      begin
         msix_enable <= cfg_req.wdata[`BIT_MSIX_EN];
         msix_function_mask <= cfg_req.wdata[`BIT_MSIX_MASK];
      end
   end

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         link_disable <= `RST_BIT;
      else if (wr_link_ctrl && cfg_req.be[0] && IS_ROOT)
         link_disable <= cfg_req.wdata[`BIT_LINK_DISABLE];
   end

   // Initiating a function level reset is a one-cycle pulse; the bit itself reads zero.
   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         flr_request <= `RST_BIT;
      else
         flr_request <= wr_dev_ctrl && cfg_req.be[1] && cfg_req.wdata[`BIT_DEV_CTRL_FLR]
            && FLR_CAP;
   end

   // ==========================================================================
   // Link layer active state and surprise down detection
   logic link_active_s;
   logic link_active_d1_q;
   logic sd_detect;
   logic sd_status_q;

   sync_two_ff #(
      .W(1)
   ) u_link_sync (
      .mclk(mclk),
      .rst_n(rst_n_q),
      .d(link_active_in),
      .q(link_active_s)
   );

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         link_active_d1_q <= `RST_BIT;
         link_layer_active_state <= `RST_BIT;
      end
      else
      begin
         link_active_d1_q <= link_active_s;
         link_layer_active_state <= link_active_s && DLA_CAP;
      end
   end

   // A drop that software asked for through link disable is not a surprise.
   assign sd_detect = SD_CAP && link_active_d1_q && !link_active_s && !link_disable;

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         surprise_down_event <= `RST_BIT;
      else
         surprise_down_event <= sd_detect;
   end

   // Write one to clear; a new detection in the same cycle keeps the bit set.
   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         sd_status_q <= `RST_BIT;
      else if (sd_detect)
         sd_status_q <= 1'b1;
      else if (wr_err && cfg_req.be[0] && cfg_req.wdata[`BIT_SURPRISE_DOWN])
         sd_status_q <= 1'b0;
   end

   // ==========================================================================
   // Legacy interrupt passing
   localparam logic HAS_PIN = (LEGACY_PIN != INT_NONE);

   // Message interrupts take over from the pin once software enables them.
   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         legacy_int_out <= `RST_BIT;
         app_int_ack <= `RST_BIT;
      end
      else
      begin
         legacy_int_out <= HAS_PIN && app_int_req && !msi_enable && !msix_enable;
         app_int_ack <= HAS_PIN && core_int_ack;
      end
   end

   // ==========================================================================
   // Read path
   logic [31:0] rd_word;

   always_comb
   begin
      rd_word = `RST_WORD;
      case (cfg_req.addr)
         `OFF_INT_LINE:
         begin
            rd_word[15:8] = {5'h00, LEGACY_PIN};
            rd_word[7:0] = int_line_q;
         end
         `OFF_MSI_CTRL:
         begin
            rd_word[7:0] = `CAP_ID_MSI;
            rd_word[15:8] = MSI_NEXT;
            rd_word[`BIT_MSI_EN] = msi_enable;
            rd_word[`MSI_MMC_LSB +: 3] = MMC;
            rd_word[`MSI_MME_LSB +: 3] = msi_multi_enabled;
         end
         `OFF_MSIX_CTRL:
         begin
            if (MSIX_ON)
            begin
               rd_word[7:0] = `CAP_ID_MSIX;
               rd_word[15:8] = 8'(`OFF_PCIE_CAP);
               rd_word[`MSIX_SIZE_LSB +: 11] = MSIX_TABLE_SIZE;
               rd_word[`BIT_MSIX_MASK] = msix_function_mask;
               rd_word[`BIT_MSIX_EN] = msix_enable;
            end
         end
         `OFF_MSIX_TABLE:
         begin
            if (MSIX_ON)
               rd_word = {MSIX_TABLE_OFFSET[31:3], TABLE_SEL};
         end
         `OFF_MSIX_PENDING:
         begin
            if (MSIX_ON)
               rd_word = {PENDING_OFFSET[31:3], PENDING_SEL};
         end
         `OFF_PCIE_CAP:
         begin
            rd_word[7:0] = `CAP_ID_PCIE;
            rd_word[`PCIE_TYPE_LSB +: 4] = IS_ROOT ? `PCIE_TYPE_RP : `PCIE_TYPE_EP;
         end
         `OFF_DEV_CAP:
            rd_word[`BIT_FLR_CAP] = FLR_CAP;
         `OFF_LINK_CAP:
         begin
            rd_word[`BIT_SD_CAP] = SD_CAP;
            rd_word[`BIT_DLA_CAP] = DLA_CAP;
         end
         `OFF_LINK_CTRL:
         begin
            rd_word[`BIT_LINK_DISABLE] = link_disable;
            rd_word[`BIT_DLA_STATE] = link_layer_active_state;
         end
         `OFF_SLOT_CAP:
            rd_word[`BIT_HOT_PLUG] = HP_CAP;
         `OFF_ERR_STATUS:
            rd_word[`BIT_SURPRISE_DOWN] = sd_status_q;
         default:
            rd_word = `RST_WORD;
      endcase
   end

   // Every request, read or write, completes one cycle later.
   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         cfg_rsp <= '0;
      else
      begin
         cfg_rsp.valid <= cfg_req.rd || cfg_req.wr;
         cfg_rsp.rdata <= cfg_req.rd ? rd_word : `RST_WORD;
      end
   end

endmodule // cap_fields

// ==== hdl/sync_two_ff.sv ====
// Two flip-flop synchroniser for levels arriving from outside the mclk domain.
// Assumes a reset already released synchronously to mclk.
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // ==========================================================================
   // Only the second stage reads the first.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule // sync_two_ff

// ==== shared/cap_fields_cfg.svh ====
// Offsets, field positions, reset values and fixed codes of the capability fields.
// Assumes byte addresses within a 4 KB configuration space of one function.
`ifndef CAP_FIELDS_CFG_SVH
`define CAP_FIELDS_CFG_SVH

// ==========================================================================
// Register offsets
`define OFF_INT_LINE 12'h03c
`define OFF_MSI_CTRL 12'h050
`define OFF_MSIX_CTRL 12'h068
`define OFF_MSIX_TABLE 12'h06c
`define OFF_MSIX_PENDING 12'h070
`define OFF_PCIE_CAP 12'h080
`define OFF_DEV_CAP 12'h084
`define OFF_DEV_CTRL 12'h088
`define OFF_LINK_CAP 12'h090
`define OFF_LINK_CTRL 12'h094
`define OFF_SLOT_CAP 12'h098
`define OFF_ERR_STATUS 12'h104

// ==========================================================================
// Field positions
`define BIT_FLR_CAP 28
`define BIT_DEV_CTRL_FLR 15
`define BIT_SD_CAP 19
`define BIT_DLA_CAP 20
`define BIT_LINK_DISABLE 4
`define BIT_DLA_STATE 29
`define BIT_HOT_PLUG 6
`define BIT_SURPRISE_DOWN 5
`define BIT_MSI_EN 16
`define MSI_MMC_LSB 17
`define MSI_MME_LSB 20
`define BIT_MSIX_MASK 30
`define BIT_MSIX_EN 31
`define MSIX_SIZE_LSB 16
`define PCIE_TYPE_LSB 20

// ==========================================================================
// Fixed codes and reset values
`define CAP_ID_MSI 8'h05
`define CAP_ID_MSIX 8'h11
`define CAP_ID_PCIE 8'h10
`define PCIE_TYPE_EP 4'h0
`define PCIE_TYPE_RP 4'h4
`define BAR_LAST 3'h5
`define RST_BIT 1'b0
`define RST_MME 3'h0
`define RST_INT_LINE 8'h00
`define RST_WORD 32'h00000000

`endif

// ==== shared/cap_fields_pkg.sv ====
// Types shared by the capability field bank: port modes, interrupt pins, request carriers.
// Assumes the constants of cap_fields_cfg.svh are included where numbers are needed.
package cap_fields_pkg;

   // ==========================================================================
   // Modes
   typedef enum logic [1:0] {
      PORT_ENDPOINT = 2'h0,
      PORT_ROOT = 2'h1
   } port_type_e;

   typedef enum logic [2:0] {
      INT_NONE = 3'h0,
      INT_A = 3'h1,
      INT_B = 3'h2,
      INT_C = 3'h3,
      INT_D = 3'h4
   } legacy_pin_e;

   // ==========================================================================
   // Configuration request and completion
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } cfg_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } cfg_rsp_s;

endpackage
